// File: hdl/scr_pkg.sv
package scr_pkg;
	////////////////////////////////////////////////////////////////////////
	// register map, byte addresses on the local port
	localparam int         SCR_ADDR_W     = 8;
	localparam logic [7:0] SCR_OFS_CFG    = 8'h10;
	localparam logic [7:0] SCR_OFS_STAT   = 8'h14;
	localparam logic [7:0] SCR_OFS_SWR    = 8'h18;

	////////////////////////////////////////////////////////////////////////
	// module_configuration fields
	localparam int         SCR_CFG_IOZ    = 0;
	localparam int         SCR_CFG_PLL    = 1;
	localparam int         SCR_CFG_MCLK   = 2;
	localparam int         SCR_CFG_SCLK   = 3;
	localparam int         SCR_CFG_USB    = 4;
	localparam int         SCR_CFG_MISC   = 5;
	localparam int         SCR_CFG_MEM    = 6;
	localparam logic [7:0] SCR_CFG_RST    = 8'h10;
	localparam logic [7:0] SCR_CFG_WMASK  = 8'h7F;

	////////////////////////////////////////////////////////////////////////
	// module_status fields
	localparam int         SCR_ST_ENV_LSB = 0;
	localparam int         SCR_ST_ENV_MSB = 2;
	localparam int         SCR_ST_PBUSY   = 3;
	localparam int         SCR_ST_DBUSY   = 4;
	localparam int         SCR_ST_WD      = 6;
	localparam int         SCR_ST_ISP     = 7;

	////////////////////////////////////////////////////////////////////////
	// software_reset_unlock keys and timing
	localparam logic [7:0] SCR_KEY_FIRST  = 8'hE1;
	localparam logic [7:0] SCR_KEY_ISP    = 8'h3E;
	localparam logic [7:0] SCR_KEY_CLR    = 8'h0E;
	localparam logic [6:0] SCR_WIN_CYC    = 7'h7F;
	localparam logic [3:0] SCR_BOOT_UNDEF = 4'hF;
	localparam int         SCR_MEM_SLOW_NS = 5;

	// unlock sequence states
	typedef enum logic {
		SCR_IDLE,
		SCR_ARMED
	} scr_seq_t;
endpackage

// File: hdl/scr_top.sv
//////////////////////////////////////////////////////////////////////////////
// Behaviour
// - reset clears configuration except usb enable
// - configuration survives every power mode
// - bit0 enables io zone external bus
// - bit1 drives pll clock on pin0
// - bit2 drives main clock on pin1
// - bit3 drives slow clock on pin2
// - bit4 clear forces transceiver low power
// - bit5 selects slow slew for misc pins
// - bit6 selects slow slew for memory bus
// - status 2:0 hold pins sampled at reset
// - status bit3 mirrors flash busy flag
// - status bit4 mirrors data flash busy
// - watchdog flag set by watchdog, write-one clears
// - isp flag set by isp reset, cleared by clr
// - e1 then 3e within 127 cycles: isp reset
// - isp reset only with rom env, boot, loader
// - after isp reset later watchdog resets reenter isp
// - e1 then 0e: unconditional reset, clears stickiness
// - software reset waits for flash to finish
module scr_top
	import scr_pkg::*;
(
	input  wire logic                  core_clk,
	input  wire logic                  rst_b,
	input  wire logic [SCR_ADDR_W-1:0] addr,
	input  wire logic [7:0]            wr_data,
	input  wire logic                  wr_stb,
	input  wire logic                  rd_stb,
	output logic      [7:0]            rd_data,
	input  wire logic [2:0]            environment_pins,
	input  wire logic                  flash_controller_busy,
	input  wire logic                  data_flash_busy,
	input  wire logic                  watchdog_reset,
	input  wire logic                  internal_rom_environment,
	input  wire logic                  external_rom_environment,
	input  wire logic [3:0]            boot_area_size_field,
	input  wire logic                  loader_present_flag,
	input  wire logic                  fw_usb_enable,
	input  wire logic                  usb_ctrl_suspend,
	output logic                       io_zone_bus_enable,
	output logic      [2:0]            env_clk_oe_b,
	output logic                       usb_xcvr_low_power,
	output logic                       misc_slow_slew,
	output logic                       mem_slow_slew,
	output logic                       soft_reset_req,
	output logic                       soft_reset_to_isp,
	output logic                       loader_boot_select
);

	//////////////////////////////////////////////////////////////////////////
	// whole state of the block
	typedef struct packed {
		logic [7:0] cfg;
		logic [2:0] env_s1;
		logic [2:0] env_s2;
		logic [2:0] env;
		logic       cap;
		logic       watchdog_reset_flag;
		logic       isp_soft_reset_flag;
		scr_seq_t   seq;
		logic [6:0] cnt;
		logic       pend;
		logic       pend_isp;
		logic       rst_pls;
		logic       rst_isp;
		logic [7:0] rdata;
		logic       ioz;
		logic [2:0] oe_b;
		logic       usb_lp;
		logic       misc_slow;
		logic       mem_slow;
	} scr_state_t;

	localparam scr_state_t SCR_RST_ST = '{
		cfg:    SCR_CFG_RST,
		cap:    1'b1,
		seq:    SCR_IDLE,
		oe_b:   3'b111,
		usb_lp: 1'b1,
		default: '0
	};

	scr_state_t s_reg;
	scr_state_t s_next;

	//////////////////////////////////////////////////////////////////////////
	// address decode shared by all strobes
	function automatic logic scr_hit(
		input logic [SCR_ADDR_W-1:0] a,
		input logic [7:0]            ofs
	);
		scr_hit = (a == ofs);
	endfunction

	logic       cfg_wr;
	logic       stat_wr;
	logic       swr_wr;
	logic       isp_ok;
	logic       issue;
	logic [7:0] stat_val;

	// write strobes per register
	assign cfg_wr  = wr_stb && scr_hit(addr, SCR_OFS_CFG);
	assign stat_wr = wr_stb && scr_hit(addr, SCR_OFS_STAT);
	assign swr_wr  = wr_stb && scr_hit(addr, SCR_OFS_SWR);

	// conditions allowing an isp entry
	assign isp_ok = (internal_rom_environment || external_rom_environment)
		&& (boot_area_size_field != SCR_BOOT_UNDEF)
		&& loader_present_flag;

	// pending reset leaves once flash is idle
	assign issue = s_reg.pend && !flash_controller_busy;

	//////////////////////////////////////////////////////////////////////////
	// status byte as software sees it
	always_comb
	begin
		stat_val = 8'h00;
		stat_val[SCR_ST_ENV_MSB:SCR_ST_ENV_LSB] = s_reg.env;
		stat_val[SCR_ST_PBUSY] = flash_controller_busy;
		stat_val[SCR_ST_DBUSY] = data_flash_busy;
		stat_val[SCR_ST_WD] = s_reg.watchdog_reset_flag;
		stat_val[SCR_ST_ISP] = s_reg.isp_soft_reset_flag;
	end

	//////////////////////////////////////////////////////////////////////////
	// next state
	always_comb
	begin
		s_next = s_reg;
		s_next.rst_pls = 1'b0;
		// pin synchroniser
		s_next.env_s1 = environment_pins;
		s_next.env_s2 = s_reg.env_s1;

		// capture pins once after any reset
		if (s_reg.cap)
		begin
			s_next.env = s_reg.env_s2;
			s_next.cap = 1'b0;
		end

		// configuration write, no power mode touches it
		if (cfg_wr)
		begin
			s_next.cfg = wr_data & SCR_CFG_WMASK;
		end

		// watchdog flag, set wins over clear
		if (stat_wr && wr_data[SCR_ST_WD])
		begin
			s_next.watchdog_reset_flag = 1'b0;
		end
		if (watchdog_reset)
		begin
			s_next.watchdog_reset_flag = 1'b1;
		end

		// unlock sequence
		case (s_reg.seq)
			SCR_IDLE:
			begin
				if (swr_wr && (wr_data == SCR_KEY_FIRST) && !s_reg.pend)
				begin
					s_next.seq = SCR_ARMED;
					s_next.cnt = 7'h01;
				end
			end
			SCR_ARMED:
			begin
				s_next.cnt = s_reg.cnt + 7'h01;
				if (swr_wr)
				begin
					s_next.seq = SCR_IDLE;
					if (wr_data == SCR_KEY_FIRST)
					begin
						s_next.seq = SCR_ARMED;
						s_next.cnt = 7'h01;
					end
					else if ((wr_data == SCR_KEY_ISP) && isp_ok)
					begin
						s_next.pend     = 1'b1;
						s_next.pend_isp = 1'b1;
					end
					else if (wr_data == SCR_KEY_CLR)
					begin
						s_next.pend     = 1'b1;
						s_next.pend_isp = 1'b0;
					end
				end
				else if (s_reg.cnt == SCR_WIN_CYC)
				begin
					s_next.seq = SCR_IDLE;
				end
			end
			default:
			begin
				s_next.seq = SCR_IDLE;
			end
		endcase

		// software reset leaves the block
		if (issue)
		begin
			s_next.pend    = 1'b0;
			s_next.rst_pls = 1'b1;
			s_next.rst_isp = s_reg.pend_isp;
			s_next.isp_soft_reset_flag  = s_reg.pend_isp;
			s_next.seq     = SCR_IDLE;
		end

		// internal resets reinitialise configuration and sample pins
		if (issue || watchdog_reset)
		begin
			s_next.cfg = SCR_CFG_RST;
			s_next.cap = 1'b1;
		end

		// registered pin controls
		s_next.ioz       = s_next.cfg[SCR_CFG_IOZ];
		s_next.oe_b[0]   = !s_next.cfg[SCR_CFG_PLL];
		s_next.oe_b[1]   = !s_next.cfg[SCR_CFG_MCLK];
		s_next.oe_b[2]   = !s_next.cfg[SCR_CFG_SCLK];
		s_next.usb_lp    = !(s_next.cfg[SCR_CFG_USB] && fw_usb_enable
			&& !usb_ctrl_suspend);
		s_next.misc_slow = s_next.cfg[SCR_CFG_MISC];
		s_next.mem_slow  = s_next.cfg[SCR_CFG_MEM];

		// read data, valid only in the cycle after the strobe
		s_next.rdata = 8'h00;
		if (rd_stb)
		begin
			if (scr_hit(addr, SCR_OFS_CFG))
			begin
				s_next.rdata = s_reg.cfg;
			end
			else if (scr_hit(addr, SCR_OFS_STAT))
			begin
				s_next.rdata = stat_val;
			end
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// state register
	always_ff @(posedge core_clk)
	begin
		if (!rst_b)
		begin
			s_reg        <= SCR_RST_ST;
			// pins keep flowing so the capture after release sees them
			s_reg.env_s1 <= s_next.env_s1;
			s_reg.env_s2 <= s_next.env_s2;
		end
		else
		begin
			s_reg <= s_next;
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// outputs straight from flops
	assign rd_data            = s_reg.rdata;
	assign io_zone_bus_enable = s_reg.ioz;
	assign env_clk_oe_b       = s_reg.oe_b;
	assign usb_xcvr_low_power = s_reg.usb_lp;
	assign misc_slow_slew     = s_reg.misc_slow;
	assign mem_slow_slew      = s_reg.mem_slow;
	assign soft_reset_req     = s_reg.rst_pls;
	assign soft_reset_to_isp  = s_reg.rst_isp;
	assign loader_boot_select = s_reg.isp_soft_reset_flag;

	//////////////////////////////////////////////////////////////////////////
	// checks
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_b);

	property p_cfg_reset;
		$rose(rst_b) |-> (s_reg.cfg == SCR_CFG_RST) && usb_xcvr_low_power;
	endproperty
	a_cfg_reset: assert property (p_cfg_reset)
		else $error("configuration not at reset value");

	property p_cfg_hold;
		!cfg_wr && !issue && !watchdog_reset |=> $stable(s_reg.cfg);
	endproperty
	a_cfg_hold: assert property (p_cfg_hold)
		else $error("configuration changed without write");

	property p_pins;
		cfg_wr && !issue && !watchdog_reset |=> (io_zone_bus_enable == $past(wr_data[0]))
			&& (env_clk_oe_b == ~$past(wr_data[3:1]))
			&& (mem_slow_slew == $past(wr_data[6]));
	endproperty
	a_pins: assert property (p_pins)
		else $error("pin controls do not follow write");

	property p_usb_force;
		!s_next.cfg[SCR_CFG_USB] |=> usb_xcvr_low_power;
	endproperty
	a_usb_force: assert property (p_usb_force)
		else $error("transceiver not forced low power");

	property p_env_hold;
		!s_reg.cap |=> $stable(s_reg.env);
	endproperty
	a_env_hold: assert property (p_env_hold)
		else $error("sampled environment changed");

	property p_busy_read;
		rd_stb && scr_hit(addr, SCR_OFS_STAT)
			|=> rd_data[SCR_ST_PBUSY] == $past(flash_controller_busy);
	endproperty
	a_busy_read: assert property (p_busy_read)
		else $error("busy mirror wrong");

	property p_wd_set;
		watchdog_reset |=> s_reg.watchdog_reset_flag;
	endproperty
	a_wd_set: assert property (p_wd_set)
		else $error("watchdog flag not set");

	property p_isp_seq;
		(s_reg.seq == SCR_ARMED) && swr_wr && (wr_data == SCR_KEY_ISP) && isp_ok
			|=> s_reg.pend && s_reg.pend_isp;
	endproperty
	a_isp_seq: assert property (p_isp_seq)
		else $error("isp sequence not taken");

	property p_flash_wait;
		s_reg.pend && flash_controller_busy |=> !soft_reset_req && s_reg.pend;
	endproperty
	a_flash_wait: assert property (p_flash_wait)
		else $error("reset issued while flash busy");

	property p_timeout;
		(s_reg.seq == SCR_ARMED) && (s_reg.cnt == SCR_WIN_CYC) && !swr_wr
			|=> (s_reg.seq == SCR_IDLE) ##1 !s_reg.pend;
	endproperty
	a_timeout: assert property (p_timeout)
		else $error("late sequence not abandoned");

	property p_clr_flag;
		s_reg.pend && !s_reg.pend_isp && !flash_controller_busy
			|=> !loader_boot_select && soft_reset_req && !soft_reset_to_isp;
	endproperty
	a_clr_flag: assert property (p_clr_flag)
		else $error("clear reset did not drop isp flag");

	property p_misc_slew;
		cfg_wr && !issue && !watchdog_reset
			|=> misc_slow_slew == $past(wr_data[SCR_CFG_MISC]);
	endproperty
	a_misc_slew: assert property (p_misc_slew)
		else $error("slew control does not follow write");

	property p_wd_clear;
		stat_wr && wr_data[SCR_ST_WD] && !watchdog_reset |=> !s_reg.watchdog_reset_flag;
	endproperty
	a_wd_clear: assert property (p_wd_clear)
		else $error("watchdog flag not cleared by write");

	property p_isp_flag;
		issue && s_reg.pend_isp |=> loader_boot_select && soft_reset_req && soft_reset_to_isp;
	endproperty
	a_isp_flag: assert property (p_isp_flag)
		else $error("isp flag not set by isp reset");

	property p_sticky_hold;
		!issue |=> $stable(loader_boot_select);
	endproperty
	a_sticky_hold: assert property (p_sticky_hold)
		else $error("isp stickiness changed without soft reset");

endmodule // scr_top

// File: tb/scr_top_tb.sv
module scr_top_tb
	import scr_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin fail_count++; \
		$display("BAD %s exp %h got %h", n, e, g); end end

	logic                  core_clk;
	logic                  rst_b;
	logic [SCR_ADDR_W-1:0] addr;
	logic [7:0]            wr_data;
	logic                  wr_stb;
	logic                  rd_stb;
	logic [7:0]            rd_data;
	logic [2:0]            environment_pins;
	logic                  flash_controller_busy;
	logic                  data_flash_busy;
	logic                  watchdog_reset;
	logic                  internal_rom_environment;
	logic                  external_rom_environment;
	logic [3:0]            boot_area_size_field;
	logic                  loader_present_flag;
	logic                  fw_usb_enable;
	logic                  usb_ctrl_suspend;
	logic                  io_zone_bus_enable;
	logic [2:0]            env_clk_oe_b;
	logic                  usb_xcvr_low_power;
	logic                  misc_slow_slew;
	logic                  mem_slow_slew;
	logic                  soft_reset_req;
	logic                  soft_reset_to_isp;
	logic                  loader_boot_select;
	logic [7:0]            exp_q[$];
	logic [7:0]            exp_v;
	logic [7:0]            v;
	logic                  rd_seen;
	logic                  isp_e;
	logic                  wd_e;
	int                    req_n;
	int                    fail_count;
	int                    total_checks;

	scr_top u_scr_top (
		.core_clk                 (core_clk),
		.rst_b                    (rst_b),
		.addr                     (addr),
		.wr_data                  (wr_data),
		.wr_stb                   (wr_stb),
		.rd_stb                   (rd_stb),
		.rd_data                  (rd_data),
		.environment_pins         (environment_pins),
		.flash_controller_busy    (flash_controller_busy),
		.data_flash_busy          (data_flash_busy),
		.watchdog_reset           (watchdog_reset),
		.internal_rom_environment (internal_rom_environment),
		.external_rom_environment (external_rom_environment),
		.boot_area_size_field     (boot_area_size_field),
		.loader_present_flag      (loader_present_flag),
		.fw_usb_enable            (fw_usb_enable),
		.usb_ctrl_suspend         (usb_ctrl_suspend),
		.io_zone_bus_enable       (io_zone_bus_enable),
		.env_clk_oe_b             (env_clk_oe_b),
		.usb_xcvr_low_power       (usb_xcvr_low_power),
		.misc_slow_slew           (misc_slow_slew),
		.mem_slow_slew            (mem_slow_slew),
		.soft_reset_req           (soft_reset_req),
		.soft_reset_to_isp        (soft_reset_to_isp),
		.loader_boot_select       (loader_boot_select)
	);

	////////////////////////////////////////////////////////////////////////
	// clock, 40 ns period
	initial core_clk = 1'b0;
	always #20 core_clk = ~core_clk;

	////////////////////////////////////////////////////////////////////////
	// bus driver tasks
	task automatic bus(input logic w, input logic r, input logic [7:0] a, input logic [7:0] d);
		wr_stb  <= w;
		rd_stb  <= r;
		addr    <= a;
		wr_data <= d;
		@(posedge core_clk);
	endtask

	task automatic idle(input int n);
		repeat (n) bus(1'b0, 1'b0, addr, 8'h00);
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		bus(1'b1, 1'b0, a, d);
		idle(1);
	endtask

	// note the expected byte, then issue the read
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		exp_q.push_back(e);
		bus(1'b0, 1'b1, a, 8'h00);
		idle(1);
	endtask

	// unlock pair with the second key gap cycles after the first
	task automatic key(input logic [7:0] k, input int gap);
		bus(1'b1, 1'b0, SCR_OFS_SWR, SCR_KEY_FIRST);
		idle(gap - 1);
		wr(SCR_OFS_SWR, k);
		idle(6);
	endtask

	function automatic logic [7:0] st();
		return {isp_e, wd_e, 1'b0, data_flash_busy, flash_controller_busy, environment_pins};
	endfunction

	task automatic wd_pulse();
		watchdog_reset <= 1'b1;
		idle(1);
		watchdog_reset <= 1'b0;
		idle(2);
	endtask

	task automatic print_verdict();
		if (fail_count == 0 && total_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////
	// output watcher: read data and reset pulses
	always @(negedge core_clk)
	begin
		if (rd_seen === 1'b1)
		begin
			exp_v = exp_q.pop_front();
			`CHK("rd_data", exp_v, rd_data)
		end
		rd_seen = rd_stb;
		if (soft_reset_req === 1'b1)
			req_n++;
	end

	// hang guard
	initial
	begin
		#200000;
		fail_count++;
		print_verdict();
	end

	////////////////////////////////////////////////////////////////////////
	// main sequence
	initial
	begin
		void'($urandom(1));
		{fail_count, total_checks, req_n, isp_e, wd_e, rd_seen} = '0;
		{rst_b, addr, wr_data, wr_stb, rd_stb, watchdog_reset} = '0;
		{flash_controller_busy, data_flash_busy, usb_ctrl_suspend} = '0;
		environment_pins = 3'($urandom);
		{internal_rom_environment, external_rom_environment} = 2'b10;
		boot_area_size_field = 4'h3;
		{loader_present_flag, fw_usb_enable} = 2'b11;
		repeat (12) @(posedge core_clk);
		rst_b <= 1'b1;
		idle(1);
		rd(SCR_OFS_CFG, SCR_CFG_RST);
		rd(SCR_OFS_STAT, st());
		`CHK("oe_b", 3'b111, env_clk_oe_b)
		repeat (8)
		begin
			v = 8'($urandom);
			{fw_usb_enable, usb_ctrl_suspend} <= 2'($urandom);
			{flash_controller_busy, data_flash_busy} <= 2'($urandom);
			wr(SCR_OFS_CFG, v); // active mode only
			rd(SCR_OFS_CFG, v & SCR_CFG_WMASK);
			rd(SCR_OFS_STAT, st());
			`CHK("ioz", v[0], io_zone_bus_enable)
			`CHK("oe_b", ~v[3:1], env_clk_oe_b)
			`CHK("usb_lp", ~(v[4] & fw_usb_enable & ~usb_ctrl_suspend), usb_xcvr_low_power)
			`CHK("misc", v[5], misc_slow_slew)
			`CHK("mem", v[6], mem_slow_slew)
		end
		{flash_controller_busy, data_flash_busy} <= 2'b00;
		wr(8'h20, 8'hFF);
		rd(8'h20, 8'h00);
		rd(SCR_OFS_SWR, 8'h00);
		rd(SCR_OFS_CFG, v & SCR_CFG_WMASK);
		// watchdog flag set, write of zero keeps it, write of one clears it
		wd_pulse();
		wd_e = 1'b1;
		rd(SCR_OFS_CFG, SCR_CFG_RST);
		wr(SCR_OFS_STAT, 8'hBF);
		rd(SCR_OFS_STAT, st());
		wr(SCR_OFS_STAT, 8'h40);
		wd_e = 1'b0;
		rd(SCR_OFS_STAT, st());
		// loader reset held back while flash is busy, last legal gap
		flash_controller_busy <= 1'b1; // flash work started from idle
		key(SCR_KEY_ISP, 127);
		idle(20);
		`CHK("req_n", 0, req_n)
		flash_controller_busy <= 1'b0;
		idle(6);
		`CHK("req_n", 1, req_n)
		`CHK("to_isp", 1'b1, soft_reset_to_isp)
		isp_e = 1'b1;
		rd(SCR_OFS_STAT, st());
		rd(SCR_OFS_CFG, SCR_CFG_RST);
		wd_pulse();
		wd_e = 1'b1;
		`CHK("sticky", 1'b1, loader_boot_select)
		// external reset mid-run clears both flags and the stickiness
		rst_b <= 1'b0;
		idle(2);
		rst_b <= 1'b1;
		idle(1);
		{isp_e, wd_e} = 2'b00;
		rd(SCR_OFS_STAT, st());
		`CHK("sticky", 1'b0, loader_boot_select)
		// late and wrong second keys are dropped
		key(SCR_KEY_ISP, 128);
		wr(SCR_OFS_SWR, SCR_KEY_FIRST);
		wr(SCR_OFS_SWR, 8'h55);
		wr(SCR_OFS_SWR, SCR_KEY_ISP);
		idle(6);
		`CHK("req_n", 1, req_n)
		// each failed enabling condition refuses the loader reset
		for (int i = 0; i < 3; i++)
		begin
			boot_area_size_field <= (i == 0) ? SCR_BOOT_UNDEF : 4'h3;
			loader_present_flag <= (i != 1);
			internal_rom_environment <= (i != 2);
			key(SCR_KEY_ISP, 2);
			`CHK("req_n", 1, req_n)
		end
		{internal_rom_environment, external_rom_environment} <= 2'b01;
		key(SCR_KEY_ISP, 2);
		`CHK("req_n", 2, req_n)
		`CHK("sticky", 1'b1, loader_boot_select)
		// plain reset ignores conditions and drops stickiness
		boot_area_size_field <= SCR_BOOT_UNDEF;
		key(SCR_KEY_CLR, 2);
		`CHK("req_n", 3, req_n)
		`CHK("to_isp", 1'b0, soft_reset_to_isp)
		`CHK("sticky", 1'b0, loader_boot_select)
		isp_e = 1'b0;
		rd(SCR_OFS_STAT, st());
		idle(2);
		print_verdict();
	end
endmodule // scr_top_tb
